// file: logic/crwd_exec.sv
`default_nettype none
module crwd_exec
  import crwd_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [DATA_W-1:0] dat_i,
  output logic      [DATA_W-1:0] dat_o,
  output logic                   ack_o,
  output crwd_mem_t              mem_o,
  output crwd_wdog_t             wdog_o,
  output logic                   busy_o
);

  function automatic logic is_file_clr(input logic [15:0] w);
    is_file_clr = (w[15:9] == FILE_CLR_OPC);
  endfunction

  function automatic logic is_wdog_clr(input logic [15:0] w);
    is_wdog_clr = (w == WDOG_CLR_OPC);
  endfunction

  crwd_phase_t phase_ff;
  crwd_phase_t nxt_phase;
  logic [15:0] instr_ff;
  logic [3:0]  banksel_ff;
  logic        zero_ff;
  logic        tout_ff;
  logic        pdown_ff;
  logic        ack_ff;
  logic [DATA_W-1:0] dat_ff;
  crwd_mem_t   mem_ff;
  crwd_wdog_t  wdog_ff;

  // bus decode
  wire logic       req      = cyc_i & stb_i;
  wire logic       wr_hit   = req & ack_ff & we_i & sel_i[0];
  wire logic [7:0] off      = adr_i[7:0];
  wire logic       hi_zero  = (adr_i[ADDR_W-1:8] == '0);
  wire logic       sel_ins  = hi_zero & (off == OFF_INSTR);
  wire logic       sel_bank = hi_zero & (off == OFF_BANKSEL);
  wire logic       sel_stat = hi_zero & (off == OFF_STATUS);
  wire logic       busy     = (phase_ff != PH_IDLE);
  wire logic       start    = wr_hit & sel_ins & sel_i[1] & ~busy;
  wire logic       do_fclr  = is_file_clr(instr_ff);
  wire logic       do_wclr  = is_wdog_clr(instr_ff);
  wire logic       st_wr    = wr_hit & sel_stat;
  // bank select from the operand bit
  // bank choice
  wire logic [3:0] bank     = instr_ff[BANK_BIT] ? banksel_ff : ACCESS_BANK;
  wire logic [FA_W-1:0] faddr = {bank, instr_ff[7:0]};
  wire logic [DATA_W-1:0] status_w = {{(DATA_W-4){1'b0}},
                                      busy, pdown_ff, tout_ff, zero_ff};
  wire logic [DATA_W-1:0] rd_mux =
    sel_ins  ? {{(DATA_W-16){1'b0}}, instr_ff} :
    sel_bank ? {{(DATA_W-4){1'b0}}, banksel_ff} :
    sel_stat ? status_w : '0;

  always_comb
  begin
    case (phase_ff)
      PH_IDLE: nxt_phase = start ? PH_Q1 : PH_IDLE;
      PH_Q1:   nxt_phase = PH_Q2;
      PH_Q2:   nxt_phase = PH_Q3;
      PH_Q3:   nxt_phase = PH_Q4;
      PH_Q4:   nxt_phase = PH_IDLE;
      default: nxt_phase = PH_IDLE;
    endcase
  end

  wire logic nxt_q2 = (nxt_phase == PH_Q2);
  wire logic nxt_q3 = (nxt_phase == PH_Q3);
  wire logic nxt_q4 = (nxt_phase == PH_Q4);
  wire logic set_z  = (phase_ff == PH_Q4) & do_fclr;
  wire logic set_wd = (phase_ff == PH_Q3) & do_wclr;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_ff <= PH_IDLE;
      ack_ff   <= 1'b0;
      dat_ff   <= '0;
    end
    else
    begin
      phase_ff <= nxt_phase;
      ack_ff   <= req & ~ack_ff;
      dat_ff   <= rd_mux;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      instr_ff   <= INSTR_RST;
      banksel_ff <= BANK_RST;
    end
    else
    begin
      if (start)
        instr_ff <= dat_i[15:0];
      if (wr_hit & sel_bank)
        banksel_ff <= dat_i[3:0];
    end
  end

  // hardware set wins over a software write
  // zero flag set
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      zero_ff <= 1'b0;
    else if (set_z)
      zero_ff <= 1'b1;
    else if (st_wr)
      zero_ff <= dat_i[ST_ZERO];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tout_ff  <= 1'b1;
      pdown_ff <= 1'b1;
    end
    else if (set_wd)
    begin
      tout_ff  <= 1'b1;
      pdown_ff <= 1'b1;
    end
    else if (st_wr)
    begin
      tout_ff  <= dat_i[ST_TOUT];
      pdown_ff <= dat_i[ST_PDOWN];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mem_ff <= '0;
    else
    begin
      mem_ff.addr  <= faddr;
      mem_ff.re    <= nxt_q2 & do_fclr;
      mem_ff.we    <= nxt_q4 & do_fclr;
      mem_ff.wdata <= CLEAR_VAL;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wdog_ff <= '0;
    else
    begin
      wdog_ff.count_clr <= nxt_q3 & do_wclr;
      wdog_ff.post_clr  <= nxt_q3 & do_wclr;
    end
  end

  assign dat_o  = dat_ff;
  assign ack_o  = ack_ff;
  assign mem_o  = mem_ff;
  assign wdog_o = wdog_ff;
  assign busy_o = busy;

  AST_CLEAR_ZERO: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (phase_ff == PH_Q4) && do_fclr |=> zero_ff)
    else $error("zero flag not set after clear-file");

  AST_ACCESS_BANK: assert property (@(posedge clk_i)
    disable iff (rst_i)
    mem_o.we && !instr_ff[BANK_BIT] |-> mem_o.addr[11:8] == ACCESS_BANK)
    else $error("bank bit 0 did not use the fast-access bank");

  AST_SELECT_BANK: assert property (@(posedge clk_i)
    disable iff (rst_i)
    mem_o.we && instr_ff[BANK_BIT] |-> mem_o.addr[11:8] == banksel_ff)
    else $error("bank bit 1 did not use bank-select register");

  AST_PHASES: assert property (@(posedge clk_i)
    disable iff (rst_i)
    start |=> phase_ff == PH_Q1 ##1 phase_ff == PH_Q2 && mem_o.re == do_fclr
    ##1 phase_ff == PH_Q3 ##1 phase_ff == PH_Q4 && mem_o.we == do_fclr
    ##1 phase_ff == PH_IDLE)
    else $error("four-phase sequence broken");

  AST_CLEAR_WRITE: assert property (@(posedge clk_i)
    disable iff (rst_i)
    mem_o.we |-> mem_o.wdata == CLEAR_VAL && $past(mem_o.re, 2))
    else $error("clear-file write not zero or not after read");

  AST_WDOG_CLEAR: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (phase_ff == PH_Q3) && do_wclr |-> wdog_o.count_clr && wdog_o.post_clr)
    else $error("watchdog clear missing in Q3");

  AST_WDOG_FLAGS: assert property (@(posedge clk_i)
    disable iff (rst_i)
    $rose(wdog_o.count_clr) |=> tout_ff && pdown_ff && $stable(zero_ff))
    else $error("clear-watchdog status bits wrong");

  AST_WDOG_NOMEM: assert property (@(posedge clk_i)
    disable iff (rst_i)
    busy && do_wclr |-> !mem_o.re && !mem_o.we)
    else $error("clear-watchdog touched data memory");

endmodule
`default_nettype wire

// file: include/crwd_pkg.sv
`default_nettype none
package crwd_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int FA_W   = 12;

  // register byte offsets
  localparam logic [7:0] OFF_INSTR   = 8'h00;
  localparam logic [7:0] OFF_BANKSEL = 8'h04;
  localparam logic [7:0] OFF_STATUS  = 8'h08;

  // status field positions
  localparam int ST_ZERO  = 0;
  localparam int ST_TOUT  = 1;
  localparam int ST_PDOWN = 2;
  localparam int ST_BUSY  = 3;

  // instruction encodings
  localparam logic [6:0]  FILE_CLR_OPC = 7'h35;
  localparam logic [15:0] WDOG_CLR_OPC = 16'h0004;
  localparam int          BANK_BIT   = 8;

  localparam logic [3:0]  ACCESS_BANK = 4'h0;
  localparam logic [7:0]  CLEAR_VAL   = 8'h00;
  localparam logic [15:0] INSTR_RST   = 16'h0000;
  localparam logic [3:0]  BANK_RST    = 4'h0;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_Q1   = 3'b001,
    PH_Q2   = 3'b010,
    PH_Q3   = 3'b011,
    PH_Q4   = 3'b100
  } crwd_phase_t;

  typedef struct packed {
    logic [FA_W-1:0] addr;
    logic            re;
    logic            we;
    logic [7:0]      wdata;
  } crwd_mem_t;

  typedef struct packed {
    logic count_clr;
    logic post_clr;
  } crwd_wdog_t;
endpackage
`default_nettype wire

// file: dv/testbench.sv
`default_nettype none
`define CHK(a, e) \
  begin \
    samples_checked++; \
    if ((a) !== (e)) \
    begin \
      fail_count++; \
      $display("unexpected t=%0t got=%h exp=%h", $time, a, e); \
    end \
  end
module testbench
  import crwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc_i = 1'b0;
  logic              stb_i = 1'b0;
  logic              we_i = 1'b0;
  logic [ADDR_W-1:0] adr_i = '0;
  logic [3:0]        sel_i = 4'hf;
  logic [DATA_W-1:0] dat_i = '0;
  logic [DATA_W-1:0] dat_o;
  logic [DATA_W-1:0] q;
  logic              ack_o;
  logic              busy_o;
  crwd_mem_t         mem_o;
  crwd_wdog_t        wdog_o;
  int                fail_count = 0;
  int                samples_checked = 0;
  logic [4:0]        re_s;
  logic [4:0]        we_s;
  logic [4:0]        by_s;
  logic [9:0]        wd_s;
  logic [11:0]       wa;
  logic [7:0]        wd;

  always #20 clk_i = ~clk_i;

  crwd_exec uut (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cyc_i  (cyc_i),
    .stb_i  (stb_i),
    .we_i   (we_i),
    .adr_i  (adr_i),
    .sel_i  (sel_i),
    .dat_i  (dat_i),
    .dat_o  (dat_o),
    .ack_o  (ack_o),
    .mem_o  (mem_o),
    .wdog_o (wdog_o),
    .busy_o (busy_o)
  );

  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one classic cycle; the leading edge keeps cyc low between requests
  task wb(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
          input logic w);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  // start an instruction and record five cycles of outputs mid-cycle
  task exec(input logic [15:0] ins);
    wb(32'h0, {16'h0, ins}, 1'b1);
    wa = '0;
    wd = 8'hff;
    for (int k = 0; k < 5; k++)
    begin
      @(negedge clk_i);
      re_s[k] = mem_o.re;
      we_s[k] = mem_o.we;
      by_s[k] = busy_o;
      wd_s[2*k +: 2] = wdog_o;
      if (mem_o.we === 1'b1)
      begin
        wa = mem_o.addr;
        wd = mem_o.wdata;
      end
    end
  endtask

  task t_clear_file(input logic a, input logic [7:0] f,
                    input logic [3:0] bank);
    exec({7'h35, a, f});
    `CHK(re_s, 5'b00010)
    `CHK(we_s, 5'b01000)
    `CHK(by_s, 5'b01111)
    `CHK(wd_s, 10'h000)
    `CHK(wa, {(a ? bank : 4'h0), f})
    `CHK(wd, 8'h00)
    wb(32'h8, 32'h0, 1'b0);
    `CHK(q[3:0], 4'h7)
  endtask

  task t_clear_wdog;
    wb(32'h8, 32'h0, 1'b1);
    exec(16'h0004);
    `CHK(re_s, 5'b00000)
    `CHK(we_s, 5'b00000)
    `CHK(wd_s, 10'h030)
    wb(32'h8, 32'h0, 1'b0);
    `CHK(q[3:0], 4'h6)
  endtask

  initial
  begin
    repeat (2000) @(posedge clk_i);
    fail_count++;
    stop_test();
  end

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(32'h8, 32'h0, 1'b0);
    `CHK(q, 32'h6)
    wb(32'hc, 32'hffff_ffff, 1'b1);
    wb(32'hc, 32'h0, 1'b0);
    `CHK(q, 32'h0)
    wb(32'h4, 32'h5, 1'b1);
    wb(32'h4, 32'h0, 1'b0);
    `CHK(q, 32'h5)
    t_clear_file(1'b1, 8'h3c, 4'h5);
    t_clear_file(1'b0, 8'hc3, 4'h5);
    t_clear_wdog();
    stop_test();
  end
endmodule
`default_nettype wire
